// ### hw/xpc_pkg.sv
// Purpose: Constants and types for the crosspoint control-port host controller
// Assumes: 125 MHz system clock; device pins are level sensitive
// Notes: Pin timing figures are conservative defaults, not device limits
package xpc_pkg;
  // ****************************************
  // Register map of the controller
  // ****************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RBDATA = 4'h2;
  // Command word fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_BANK_BIT = 14;
  localparam int CMD_OP_LSB = 16;
  // Status word fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_ADDR_BIT = 1;
  localparam int ST_ERR_RD_BIT = 2;
  localparam int ST_ERR_PROG_BIT = 3;
  localparam int ST_PROG_OK_BIT = 4;
  // Command opcodes
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_UPDATE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;
  // ****************************************
  // Device address and data codes
  // ****************************************
  localparam int NUM_OUTPUTS = 34;
  localparam logic [5:0] ADDR_LAST = 6'h21;
  localparam logic [5:0] ADDR_BCAST = 6'h3F;
  localparam logic [5:0] CODE_DISABLE = 6'h3F;
  localparam logic [3:0] CUR_RESET = 4'h7;
  // ****************************************
  // Pin timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int SETUP_NS = 16;
  localparam int PULSE_NS = 24;
  localparam int RB_NS = 64;
  localparam int HOLD_NS = 16;
  localparam int RST_NS = 1000;
  // Least times round up, never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [7:0] SETUP_CYC = 8'(ns2cyc(SETUP_NS));
  localparam logic [7:0] PULSE_CYC = 8'(ns2cyc(PULSE_NS));
  localparam logic [7:0] RB_CYC = 8'(ns2cyc(RB_NS));
  localparam logic [7:0] HOLD_CYC = 8'(ns2cyc(HOLD_NS));
  localparam logic [7:0] RST_CYC = 8'(ns2cyc(RST_NS));
  // Controller states
  typedef enum logic [2:0] {ST_IDLE, ST_PWRUP, ST_SETUP, ST_STROBE, ST_HOLD} xpc_state_e;
endpackage

// ### hw/xpc_host_ctrl.sv
// Purpose: Host controller that programs a dual-rank crosspoint over its parallel pins
// Assumes: Software issues one command at a time through the register port
// Notes: Readback data pass a two-flop synchroniser before sampling
`timescale 1ns/1ps
`default_nettype none
module xpc_host_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Device address and data pins
  output logic o_bank_select_bit,
  output logic [5:0] o_output_address,
  input wire logic [5:0] i_data_bits,
  output logic [5:0] o_data_bits,
  output logic o_data_bits_oe,
  // Device control pins, active low
  output logic o_first_rank_write_n,
  output logic o_update_n,
  output logic o_readback_enable_n,
  output logic o_chip_select_n,
  output logic o_reset_n
);
  // ****************************************
  // Declarations
  // ****************************************
  xpc_pkg::xpc_state_e state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [1:0] op;
  logic [1:0] next_op;
  logic [5:0] d_meta, d_sync;
  logic [5:0] rb_data;
  logic err_addr, err_rd, err_prog;
  logic [33:0] prog_conn, prog_cur;
  wire cnt_done = (cnt == 8'h00);
  // ****************************************
  // Command decode
  // ****************************************
  wire [1:0] cmd_op = i_wdata[xpc_pkg::CMD_OP_LSB +: 2];
  wire [5:0] cmd_addr = i_wdata[xpc_pkg::CMD_ADDR_LSB +: 6];
  wire cmd_bank = i_wdata[xpc_pkg::CMD_BANK_BIT];
  wire [5:0] cmd_data = i_wdata[xpc_pkg::CMD_DATA_LSB +: 6];
  wire cmd_wr = i_wr && (i_addr == xpc_pkg::REG_CMD) && (state == xpc_pkg::ST_IDLE);
  wire stat_wr = i_wr && (i_addr == xpc_pkg::REG_STATUS);
  wire is_bcast = (cmd_addr == xpc_pkg::ADDR_BCAST);
  wire is_single = (cmd_addr <= xpc_pkg::ADDR_LAST);
  wire addr_ok = is_single || is_bcast;
  wire prog_ok = (&prog_conn) && (&prog_cur);
  // Refusals are checked here so the device never sees a bad request
  wire bad_wr = (cmd_op == xpc_pkg::OP_WRITE) && !addr_ok;
  wire bad_rd = (cmd_op == xpc_pkg::OP_READ) && !is_single;
  wire bad_upd = (cmd_op == xpc_pkg::OP_UPDATE) && !prog_ok;
  wire accept = cmd_wr && !bad_wr && !bad_rd && !bad_upd;
  wire [33:0] sel_mask = is_bcast ? {34{1'b1}} : (34'h1 << cmd_addr);
  wire wr_acc = accept && (cmd_op == xpc_pkg::OP_WRITE);
  // Upper data bits are don't-care in the current bank; drive them low
  wire [5:0] pin_data = cmd_bank ? {2'b00, cmd_data[3:0]} : cmd_data;
  // ****************************************
  // Sequencer
  // ****************************************
  // Each pin action is a level held for a counted time, not an edge
  always_comb begin
    next_state = state;
    next_cnt = cnt_done ? 8'h00 : cnt - 8'h01;
    next_op = accept ? cmd_op : op;
    case (state)
      xpc_pkg::ST_PWRUP: begin
        if (cnt_done) begin
          next_state = xpc_pkg::ST_IDLE;
        end
      end
      xpc_pkg::ST_IDLE: begin
        if (accept && cmd_op == xpc_pkg::OP_RESET) begin
          next_state = xpc_pkg::ST_PWRUP;
          next_cnt = xpc_pkg::RST_CYC - 8'h01;
        end else if (accept) begin
          next_state = xpc_pkg::ST_SETUP;
          next_cnt = xpc_pkg::SETUP_CYC - 8'h01;
        end
      end
      xpc_pkg::ST_SETUP: begin
        if (cnt_done) begin
          next_state = xpc_pkg::ST_STROBE;
          next_cnt = ((op == xpc_pkg::OP_READ) ? xpc_pkg::RB_CYC : xpc_pkg::PULSE_CYC) - 8'h01;
        end
      end
      xpc_pkg::ST_STROBE: begin
        if (cnt_done) begin
          next_state = xpc_pkg::ST_HOLD;
          next_cnt = xpc_pkg::HOLD_CYC - 8'h01;
        end
      end
      xpc_pkg::ST_HOLD: begin
        if (cnt_done) begin
          next_state = xpc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = xpc_pkg::ST_IDLE;
      end
    endcase
  end
  // Next pin levels, all registered before reaching the pins
  wire nx_frame = (next_state == xpc_pkg::ST_SETUP) || (next_state == xpc_pkg::ST_STROBE) ||
                  (next_state == xpc_pkg::ST_HOLD);
  wire nx_strobe = (next_state == xpc_pkg::ST_STROBE);
  wire next_cs_n = !nx_frame;
  // Only one strobe per command, so write and readback never overlap
  wire next_we_n = !(nx_strobe && next_op == xpc_pkg::OP_WRITE);
  wire next_upd_n = !(nx_strobe && next_op == xpc_pkg::OP_UPDATE);
  wire next_re_n = !(nx_strobe && next_op == xpc_pkg::OP_READ);
  // Bus is released for the whole read frame, which gives turnaround margin
  wire next_oe = nx_frame && (next_op == xpc_pkg::OP_WRITE);
  wire next_reset_n = (next_state != xpc_pkg::ST_PWRUP);
  wire rb_take = (state == xpc_pkg::ST_STROBE) && cnt_done && (op == xpc_pkg::OP_READ);
  // State and pin registers; power-up starts with the reset pin held low
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= xpc_pkg::ST_PWRUP;
      cnt <= xpc_pkg::RST_CYC - 8'h01;
      op <= xpc_pkg::OP_RESET;
      o_chip_select_n <= 1'b1;
      o_first_rank_write_n <= 1'b1;
      o_update_n <= 1'b1;
      o_readback_enable_n <= 1'b1;
      o_data_bits_oe <= 1'b0;
      o_reset_n <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      o_chip_select_n <= next_cs_n;
      o_first_rank_write_n <= next_we_n;
      o_update_n <= next_upd_n;
      o_readback_enable_n <= next_re_n;
      o_data_bits_oe <= next_oe;
      o_reset_n <= next_reset_n;
    end
  end
  // Address and data stay stable through setup, strobe and hold
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_bank_select_bit <= 1'b0;
      o_output_address <= 6'h00;
      o_data_bits <= 6'h00;
    end else if (accept) begin
      o_bank_select_bit <= cmd_bank;
      o_output_address <= cmd_addr;
      o_data_bits <= pin_data;
    end
  end
  // ****************************************
  // Readback path
  // ****************************************
  // Pins are asynchronous to us; first flop feeds only the second
  always_ff @(posedge i_clk) begin
    d_meta <= i_data_bits;
    d_sync <= d_meta;
  end
  // Sample late in the strobe so the two-flop lag is covered
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rb_data <= 6'h00;
    end else if (rb_take) begin
      rb_data <= d_sync;
    end
  end
  // ****************************************
  // Programming tracker and status
  // ****************************************
  // A device reset leaves first rank known, but we still demand full programming
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || (next_state == xpc_pkg::ST_PWRUP)) begin
      prog_conn <= 34'h0;
      prog_cur <= 34'h0;
    end else if (wr_acc && !cmd_bank) begin
      prog_conn <= prog_conn | sel_mask;
    end else if (wr_acc) begin
      prog_cur <= prog_cur | sel_mask;
    end
  end
  // Sticky errors; a new error in the clearing cycle wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      err_addr <= 1'b0;
      err_rd <= 1'b0;
      err_prog <= 1'b0;
    end else begin
      err_addr <= (cmd_wr && bad_wr) || (err_addr && !(stat_wr && i_wdata[xpc_pkg::ST_ERR_ADDR_BIT]));
      err_rd <= (cmd_wr && bad_rd) || (err_rd && !(stat_wr && i_wdata[xpc_pkg::ST_ERR_RD_BIT]));
      err_prog <= (cmd_wr && bad_upd) || (err_prog && !(stat_wr && i_wdata[xpc_pkg::ST_ERR_PROG_BIT]));
    end
  end
  // Read mux; unmapped addresses and idle cycles read zero
  wire [31:0] stat_word = {27'h0, prog_ok, err_prog, err_rd, err_addr, state != xpc_pkg::ST_IDLE};
  wire [31:0] rd_mux = (i_addr == xpc_pkg::REG_STATUS) ? stat_word :
                       (i_addr == xpc_pkg::REG_RBDATA) ? {26'h0, rb_data} : 32'h0;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  localparam int k_pw = xpc_pkg::PULSE_CYC;
  localparam int k_rb = xpc_pkg::RB_CYC;
  localparam int k_su = xpc_pkg::SETUP_CYC;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence we_pulse_s;
    ##[k_pw:k_pw] $rose(o_first_rank_write_n);
  endsequence
  sequence rb_pulse_s;
    ##[k_rb:k_rb] $rose(o_readback_enable_n) ##1 !o_data_bits_oe;
  endsequence
  we_release_a: assert property ($fell(o_first_rank_write_n) |-> we_pulse_s)
    else $error("write strobe not released after pulse");
  rb_release_a: assert property ($fell(o_readback_enable_n) |-> rb_pulse_s)
    else $error("readback strobe length wrong");
  strobe_excl_a: assert property (!(!o_first_rank_write_n && !o_readback_enable_n))
    else $error("write and readback both low");
  rb_no_drive_a: assert property (!o_readback_enable_n |-> !o_data_bits_oe)
    else $error("data driven during readback");
  rb_no_bcast_a: assert property (!o_readback_enable_n |-> o_output_address <= xpc_pkg::ADDR_LAST)
    else $error("readback at non-single address");
  cs_gate_a: assert property ((!o_first_rank_write_n || !o_update_n || !o_readback_enable_n) |->
    !o_chip_select_n && !$past(o_chip_select_n, k_su))
    else $error("strobe without chip select setup");
  pwrup_reset_a: assert property ($fell(i_sys_rst) |-> !o_reset_n ##1 !o_reset_n)
    else $error("reset pin not held after power-up");
  upd_gate_a: assert property ($fell(o_update_n) |-> prog_ok)
    else $error("update before full programming");
  wr_addr_a: assert property (!o_first_rank_write_n |->
    (o_output_address <= xpc_pkg::ADDR_LAST || o_output_address == xpc_pkg::ADDR_BCAST))
    else $error("write to reserved address");
  cur_bits_a: assert property ((!o_first_rank_write_n && o_bank_select_bit) |-> o_data_bits[5:4] == 2'b00)
    else $error("current write with upper bits set");
endmodule
`default_nettype wire

// ### tb/xpc_dev_model.sv
// Purpose: Behavioural crosspoint control port driven by the host controller
// Assumes: Pins are sampled every nanosecond, which stands in for level logic
// Notes: A released data bus shows the inverse of the last driven word
`timescale 1ns/1ps
`default_nettype none
module xpc_dev_model (
  // Address and data pins
  input wire logic i_bank,
  input wire logic [5:0] i_addr,
  input wire logic [5:0] i_data,
  output logic [5:0] o_data,
  output logic o_oe,
  // Control pins, active low
  input wire logic i_we_n,
  input wire logic i_upd_n,
  input wire logic i_re_n,
  input wire logic i_cs_n,
  input wire logic i_rst_n,
  // Slow readback drivers
  input wire logic i_slow
);
  // ****************************************
  // Dual-rank latches
  // ****************************************
  logic [5:0] first [0:1][0:33];
  logic [5:0] second [0:1][0:33];
  logic [5:0] last = 6'h2A;
  int re_ns = 0;
  // Level evaluation each nanosecond; reserved addresses match no row
  always begin
    if (i_rst_n === 1'b0) begin
      for (int k = 0; k < 34; k++) begin
        first[0][k] = 6'h00;
        first[1][k] = 6'h00;
        second[0][k] = 6'h3F;
        second[1][k] = 6'h07;
      end
    end else if (i_cs_n === 1'b0) begin
      if (i_re_n === 1'b0) begin
        re_ns++;
      end else if (i_we_n === 1'b0) begin
        for (int k = 0; k < 34; k++) begin
          if (i_addr == k[5:0] || i_addr == 6'h3F) begin
            first[i_bank][k] = i_bank ? {2'b00, i_data[3:0]} : i_data;
          end
        end
      end
      if (i_upd_n === 1'b0) begin
        second = first;
      end
    end
    if (i_re_n !== 1'b0) begin
      re_ns = 0;
    end
    // Drive only for single addresses, after the chosen driver delay
    o_oe = (i_rst_n === 1'b1) && (i_cs_n === 1'b0) && (re_ns > (i_slow ? 24 : 0)) && (i_addr < 6'd34);
    if (o_oe) begin
      last = second[i_bank][i_addr];
    end
    o_data = o_oe ? last : ~last;
    #1;
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the crosspoint host controller
// Assumes: Controller commands are polled to completion through STATUS
// Notes: Expected readback words come from the crosspoint latch behaviour; status words come from the controller rules
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic slow = 1'b0;
  logic clash = 1'b0;
  wire logic [31:0] o_rdata;
  wire logic bank, oe, we_n, upd_n, re_n, cs_n, rst_n, dev_oe;
  wire logic [5:0] oaddr, dout, din, dev_data;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rv;
  // ****************************************
  // Clock, bus wiring and watchdog
  // ****************************************
  always #4 i_clk = ~i_clk;
  assign din = (oe === 1'b1) ? dout : dev_data;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (oe === 1'b1 && dev_oe === 1'b1) clash <= 1'b1;
    if (cycles == 30000) begin
      bad_count++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      finish_test();
    end
  end
  xpc_host_ctrl i_xpc_host_ctrl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_bank_select_bit(bank), .o_output_address(oaddr),
    .i_data_bits(din), .o_data_bits(dout), .o_data_bits_oe(oe), .o_first_rank_write_n(we_n),
    .o_update_n(upd_n), .o_readback_enable_n(re_n), .o_chip_select_n(cs_n), .o_reset_n(rst_n));
  xpc_dev_model i_xpc_dev_model (.i_bank(bank), .i_addr(oaddr), .i_data(din), .o_data(dev_data),
    .o_oe(dev_oe), .i_we_n(we_n), .i_upd_n(upd_n), .i_re_n(re_n), .i_cs_n(cs_n), .i_rst_n(rst_n),
    .i_slow(slow));
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data are valid only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus_rd(xpc_pkg::REG_STATUS, rv);
      n++;
    end while (rv[0] !== 1'b0 && n < 400);
    chk({31'h0, rv[0]}, 32'h0, "busy stuck");
  endtask
  task automatic cmd(input logic [1:0] op, input logic bk, input logic [5:0] a, input logic [5:0] d);
    bus_wr(xpc_pkg::REG_CMD, {14'h0, op, 1'b0, bk, a, 2'b00, d});
    wait_idle();
  endtask
  task automatic rb(input logic bk, input logic [5:0] a, input logic [5:0] exp);
    cmd(xpc_pkg::OP_READ, bk, a, 6'h00);
    bus_rd(xpc_pkg::REG_RBDATA, rv);
    chk(rv, {26'h0, exp}, "readback word");
  endtask
  // Compare error bits, then clear them for the next scenario
  task automatic st(input logic [31:0] exp);
    bus_rd(xpc_pkg::REG_STATUS, rv);
    chk(rv & 32'hE, exp, "status errors");
    bus_wr(xpc_pkg::REG_STATUS, 32'hE);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    bus_rd(xpc_pkg::REG_STATUS, rv);
    chk({31'h0, rv[0]}, 32'h1, "busy after reset");
    chk({31'h0, rst_n}, 32'h0, "device reset pin");
    wait_idle();
    rb(1'b0, 6'h00, 6'h3F);
    rb(1'b1, 6'h21, 6'h07);
    cmd(xpc_pkg::OP_UPDATE, 1'b0, 6'h00, 6'h00);
    st(32'h8);
    cmd(xpc_pkg::OP_WRITE, 1'b0, 6'h3F, 6'h05);
    // Only the connection bank is covered so far, so updates stay barred
    bus_rd(xpc_pkg::REG_STATUS, rv);
    chk(rv & 32'h10, 32'h0, "half programmed");
    cmd(xpc_pkg::OP_WRITE, 1'b1, 6'h3F, 6'h3A);
    cmd(xpc_pkg::OP_WRITE, 1'b0, 6'h21, 6'h3F);
    cmd(xpc_pkg::OP_WRITE, 1'b0, 6'h00, 6'h12);
    bus_rd(xpc_pkg::REG_STATUS, rv);
    chk(rv & 32'h10, 32'h10, "fully programmed");
    rb(1'b0, 6'h00, 6'h3F);
    for (int i = 0; i < 2; i++) begin
      cmd(xpc_pkg::OP_WRITE, 1'b0, (i == 1) ? 6'h3E : 6'h22, 6'h01);
      st(32'h2);
    end
    cmd(xpc_pkg::OP_UPDATE, 1'b0, 6'h11, 6'h00);
    st(32'h0);
    rb(1'b0, 6'h00, 6'h12);
    rb(1'b0, 6'h21, 6'h3F);
    rb(1'b0, 6'h11, 6'h05);
    slow = 1'b1;
    rb(1'b1, 6'h05, 6'h0A);
    slow = 1'b0;
    cmd(xpc_pkg::OP_READ, 1'b0, 6'h3F, 6'h00);
    st(32'h4);
    bus_rd(4'hF, rv);
    chk(rv, 32'h0, "unmapped read");
    chk({31'h0, clash}, 32'h0, "bus contention");
    chk({30'h0, cs_n, we_n}, 32'h3, "idle pins");
    cmd(xpc_pkg::OP_RESET, 1'b0, 6'h00, 6'h00);
    rb(1'b0, 6'h11, 6'h3F);
    rb(1'b1, 6'h05, 6'h07);
    // A device reset must force full reprogramming before the next update
    bus_rd(xpc_pkg::REG_STATUS, rv);
    chk(rv & 32'h10, 32'h0, "tracking after reset");
    finish_test();
  end
endmodule
`default_nettype wire
